// >>> src/gpio_port_bank_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"

// Functional notes
// - 48 pins over three independent ports
// - Fourth bank window answers with error
// - Pins default to plain GPIO function
// - Driver and input buffer off after reset
// - Per-pin direction register
// - Four output writes; zero bits untouched except by the data write
// - Set register drives pin high
// - Clear register drives pin low
// - Toggle register inverts output level
// - Data register loads all outputs directly
// - Level register returns sensed pin levels
// - Mask-set write enables pin interrupt
// - Mask-clear write disables pin interrupt
// - Enabled input raises interrupt on condition
// - Output writes can trigger pin interrupt
// - Per-pin level or edge sensitivity
// - Edge pins: rising only or both
module gpio_port_bank_controller (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GPIO_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`GPIO_ALL_PINS-1:0] pin_in,
   output logic [`GPIO_ALL_PINS-1:0] pin_out,
   output logic [`GPIO_ALL_PINS-1:0] pin_oe,
   output logic irq
);

   // ----------------------------------------
   // Register map, one 0x40 window per port
   // ----------------------------------------
   // Index 0: output data, write loads all bits
   // Index 1: write-one clears output bits
   // Index 2: write-one sets output bits
   // Index 3: write-one inverts output bits
   // Index 4: interrupt mask, read only
   // Index 5: write-one disables pin interrupts
   // Index 6: write-one enables pin interrupts
   // Index 7: direction, one means driving
   // Index 8: sensitivity, one means edge
   // Index 9: edge pins, one means both edges
   // Index a: input buffer enable
   // Index b: synchronised pin levels, read only
   // Index c: interrupt status, edge bits write-one-clear
   // Write-one aliases read back the register they modify

   // ----------------------------------------
   // Timing summary
   // ----------------------------------------
   // Setup, access, answer: one wait state always
   // Write lands on the edge that samples pready
   // Pin change reaches the level view after two edges
   // Pin change reaches irq after three edges
   // Low clock enable stalls bus and pins alike
   // Hazard: a stalled transfer waits for the enable

   // ----------------------------------------
   // Reset state
   // ----------------------------------------
   // Every register clears: pins are inputs
   // Input buffers off, so the level view reads zero
   // Masks clear, so irq stays low
   // Bus answer lines idle low

   // ----------------------------------------
   // Interrupt path per pin
   // ----------------------------------------
   // Source: outputs see their data bit, inputs the pin
   // Inputs only count while their buffer is enabled
   // Edge mode: rising sets, both-edge adds falling
   // A new edge beats a clear in the same cycle
   // Level mode: status tracks the source, no clear
   // Mask gates status onto the single request line

   // ----------------------------------------
   // Limitations
   // ----------------------------------------
   // Level interrupts are active high only
   // Changing direction or sensitivity can fake an edge
   // Fourth bank window refuses every access
   // Level view writes are dropped without an error
   // Upper data bits are ignored on write
   // Reads of upper bits return zero

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------

   // Known register index inside a GPIO port window
   function automatic logic reg_known(input logic [3:0] idx);
      reg_known = (idx <= `GPIO_REG_IRQ_STAT);
   endfunction

   // Bank 3 has no GPIO: its window is unmapped
   function automatic logic addr_ok(input logic [`GPIO_ADDR_W-1:0] a);
      addr_ok = (a[`GPIO_PORT_MSB:`GPIO_PORT_LSB] < 2'(`GPIO_PORTS))
         && reg_known(a[`GPIO_REG_MSB:`GPIO_REG_LSB]);
   endfunction

   // One register of a port addressed by a committing write
   function automatic logic reg_hit(input logic h, input logic [3:0] idx,
                                    input logic [3:0] code);
      reg_hit = h && (idx == code);
   endfunction

   // Lowest pin number of a port inside the 48-pin vectors
   function automatic int port_base(input logic [1:0] p);
      port_base = int'(p) * `GPIO_PINS;
   endfunction

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   logic [`GPIO_ALL_PINS-1:0] meta_r;
   logic [`GPIO_ALL_PINS-1:0] sync_r;

   // Two flops; only the second one is read by logic
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else if (ce) begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   // ----------------------------------------
   // APB slave: one wait state, write at the ready edge
   // ----------------------------------------
   logic [31:0] rd_data;
   logic rd_err;
   gpio_bank_pkg::bus_wr_s wr;
   gpio_bank_pkg::port_regs_s regs [`GPIO_PORTS];
   logic [`GPIO_PORTS-1:0] irq_any;
   // Next values of data and direction, shared with the pin flops
   gpio_bank_pkg::pins_t data_nxt_a [`GPIO_PORTS];
   gpio_bank_pkg::pins_t dir_nxt_a [`GPIO_PORTS];

   // Write commits only at the edge that samples pready high
   always_comb begin
      wr.go = psel && penable && pready && pwrite && !pslverr && ce;
      wr.port = paddr[`GPIO_PORT_MSB:`GPIO_PORT_LSB];
      wr.idx = paddr[`GPIO_REG_MSB:`GPIO_REG_LSB];
      wr.wdata = pwdata[`GPIO_PINS-1:0];
   end

   // Read mux; bits above the port width read as zero
   always_comb begin
      logic [1:0] p;
      gpio_bank_pkg::port_regs_s r;
      p = paddr[`GPIO_PORT_MSB:`GPIO_PORT_LSB];
      r = regs[0];
      rd_data = `GPIO_RST_WORD;
      rd_err = !addr_ok(paddr);
      if (p < 2'(`GPIO_PORTS)) begin
         r = regs[p];
      end
      if (!rd_err) begin
         unique case (paddr[`GPIO_REG_MSB:`GPIO_REG_LSB])
            `GPIO_REG_DATA, `GPIO_REG_CLEAR, `GPIO_REG_SET, `GPIO_REG_TOGGLE: begin
               rd_data[`GPIO_PINS-1:0] = r.data;
            end
            `GPIO_REG_MASK, `GPIO_REG_MASK_CLEAR, `GPIO_REG_MASK_SET: begin
               rd_data[`GPIO_PINS-1:0] = r.mask;
            end
            `GPIO_REG_DIR: rd_data[`GPIO_PINS-1:0] = r.dir;
            `GPIO_REG_EDGE: rd_data[`GPIO_PINS-1:0] = r.edge_sel;
            `GPIO_REG_BOTH: rd_data[`GPIO_PINS-1:0] = r.both;
            `GPIO_REG_INEN: rd_data[`GPIO_PINS-1:0] = r.inen;
            `GPIO_REG_LEVEL: begin
               // Disabled input buffers sense as zero
               rd_data[`GPIO_PINS-1:0] =
                  sync_r[port_base(p) +: `GPIO_PINS]
                  & r.inen;
            end
            `GPIO_REG_IRQ_STAT: rd_data[`GPIO_PINS-1:0] = r.irq_stat;
            default: rd_data = `GPIO_RST_WORD;
         endcase
      end
   end

   // Answer registered one cycle into the access phase
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= `GPIO_RST_WORD;
         pslverr <= 1'b0;
      end else if (ce) begin
         if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? `GPIO_RST_WORD : rd_data;
            pslverr <= rd_err;
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Per-port logic
   // ----------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < `GPIO_PORTS; gp++) begin : g_port
         localparam int BASE = port_base(2'(gp));
         logic hit;
         logic [3:0] idx;
         gpio_bank_pkg::pins_t w;
         gpio_bank_pkg::pins_t src;
         gpio_bank_pkg::pins_t src_prev_r;
         gpio_bank_pkg::pins_t event_edge;
         gpio_bank_pkg::pins_t data_nxt;
         gpio_bank_pkg::pins_t stat_nxt;
         gpio_bank_pkg::pins_t dir_nxt;
         logic hit_dir;
         logic hit_inen;
         logic hit_edge;
         logic hit_both;
         logic hit_mset;
         logic hit_mclr;
         logic hit_sclr;

         assign hit = wr.go && (wr.port == 2'(gp));
         assign idx = wr.idx;
         assign w = wr.wdata;

         // Per-register write strobes for this port
         assign hit_dir = reg_hit(hit, idx, `GPIO_REG_DIR);
         assign hit_inen = reg_hit(hit, idx, `GPIO_REG_INEN);
         assign hit_edge = reg_hit(hit, idx, `GPIO_REG_EDGE);
         assign hit_both = reg_hit(hit, idx, `GPIO_REG_BOTH);
         assign hit_mset = reg_hit(hit, idx, `GPIO_REG_MASK_SET);
         assign hit_mclr = reg_hit(hit, idx, `GPIO_REG_MASK_CLEAR);
         assign hit_sclr = reg_hit(hit, idx, `GPIO_REG_IRQ_STAT);

         // Output value: only bits written as one change, except data
         always_comb begin
            data_nxt = regs[gp].data;
            if (hit) begin
               unique case (idx)
                  `GPIO_REG_DATA: data_nxt = w;
                  `GPIO_REG_SET: data_nxt = regs[gp].data | w;
                  `GPIO_REG_CLEAR: data_nxt = regs[gp].data & ~w;
                  `GPIO_REG_TOGGLE: data_nxt = regs[gp].data ^ w;
                  default: data_nxt = regs[gp].data;
               endcase
            end
         end

         // Data flop; pin outputs come from their own flop copies fed by data_nxt
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               regs[gp].data <= `GPIO_RST_BITS;
            end else if (ce) begin
               regs[gp].data <= data_nxt;
            end
         end

         // Direction next value feeds both the register and its pin copy
         always_comb begin
            dir_nxt = regs[gp].dir;
            if (hit_dir) begin
               dir_nxt = w;
            end
         end

         // Direction and input enable both off after reset
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               regs[gp].dir <= `GPIO_RST_BITS;
               regs[gp].inen <= `GPIO_RST_BITS;
            end else if (ce) begin
               regs[gp].dir <= dir_nxt;
               if (hit_inen) regs[gp].inen <= w;
            end
         end

         // Sensitivity configuration
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               regs[gp].edge_sel <= `GPIO_RST_BITS;
               regs[gp].both <= `GPIO_RST_BITS;
            end else if (ce && hit) begin
               if (hit_edge) regs[gp].edge_sel <= w;
               if (hit_both) regs[gp].both <= w;
            end
         end

         // Mask set and clear; untouched bits keep their value
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               regs[gp].mask <= `GPIO_RST_BITS;
            end else if (ce && hit) begin
               if (hit_mset) regs[gp].mask <= regs[gp].mask | w;
               if (hit_mclr) regs[gp].mask <= regs[gp].mask & ~w;
            end
         end

         // Interrupt source: outputs see written value, inputs the pin
         always_comb begin
            src = (regs[gp].dir & regs[gp].data)
               | (~regs[gp].dir & regs[gp].inen & sync_r[BASE +: `GPIO_PINS]);
            event_edge = (src & ~src_prev_r)
               | (regs[gp].both & ~src & src_prev_r);
         end

         // Previous source, the reference for edge detection
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               src_prev_r <= `GPIO_RST_BITS;
            end else if (ce) begin
               src_prev_r <= src;
            end
         end

         // Edge bits stick, W1C, a new edge beats the clear; level bits track
         always_comb begin
            stat_nxt = regs[gp].irq_stat;
            if (hit_sclr) begin
               stat_nxt = stat_nxt & ~w;
            end
            stat_nxt = (stat_nxt | event_edge) & regs[gp].edge_sel
               | (src & ~regs[gp].edge_sel);
         end

         // Status register, frozen with the clock enable
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               regs[gp].irq_stat <= `GPIO_RST_BITS;
            end else if (ce) begin
               regs[gp].irq_stat <= stat_nxt;
            end
         end

         assign irq_any[gp] = |(stat_nxt & regs[gp].mask);

         // Hand next values to the shared pin flops
         assign data_nxt_a[gp] = data_nxt;
         assign dir_nxt_a[gp] = dir_nxt;
      end
   endgenerate

   // ----------------------------------------
   // Registered pin drive and interrupt request
   // ----------------------------------------

   // Flop copies keep every output on a register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pin_out <= '0;
         pin_oe <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         // Same next values as the registers, so pins never lag a write
         for (int i = 0; i < `GPIO_PORTS; i++) begin
            pin_out[i*`GPIO_PINS +: `GPIO_PINS] <= data_nxt_a[i];
            pin_oe[i*`GPIO_PINS +: `GPIO_PINS] <= dir_nxt_a[i];
         end
         irq <= |irq_any;
      end
   end

endmodule

`default_nettype wire

// >>> inc/gpio_bank_regs.svh
`ifndef GPIO_BANK_REGS_SVH
`define GPIO_BANK_REGS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define GPIO_PORTS 3
`define GPIO_PINS 16
`define GPIO_ALL_PINS 48
`define GPIO_ADDR_W 12

// ----------------------------------------
// Address fields: port select and word index
// ----------------------------------------
`define GPIO_PORT_MSB 7
`define GPIO_PORT_LSB 6
`define GPIO_REG_MSB 5
`define GPIO_REG_LSB 2

// ----------------------------------------
// Register word indices within one port window
// ----------------------------------------
`define GPIO_REG_DATA 4'h0
`define GPIO_REG_CLEAR 4'h1
`define GPIO_REG_SET 4'h2
`define GPIO_REG_TOGGLE 4'h3
`define GPIO_REG_MASK 4'h4
`define GPIO_REG_MASK_CLEAR 4'h5
`define GPIO_REG_MASK_SET 4'h6
`define GPIO_REG_DIR 4'h7
`define GPIO_REG_EDGE 4'h8
`define GPIO_REG_BOTH 4'h9
`define GPIO_REG_INEN 4'ha
`define GPIO_REG_LEVEL 4'hb
`define GPIO_REG_IRQ_STAT 4'hc

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPIO_RST_BITS 16'h0000
`define GPIO_RST_WORD 32'h0000_0000

`endif

// >>> inc/gpio_bank_pkg.sv
package gpio_bank_pkg;

   typedef logic [15:0] pins_t;

   // Software-visible state of one port
   typedef struct packed {
      pins_t data;
      pins_t dir;
      pins_t inen;
      pins_t edge_sel;
      pins_t both;
      pins_t mask;
      pins_t irq_stat;
   } port_regs_s;

   // One decoded bus write
   typedef struct packed {
      logic go;
      logic [1:0] port;
      logic [3:0] idx;
      pins_t wdata;
   } bus_wr_s;

endpackage

// >>> verif/gpio_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External circuits on the 48 pins
// ----------------------------------------
module gpio_far_end (
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic [47:0] ext_level,
   output logic [47:0] pin_in
);
   // Enabled driver wins; elsewhere the outside circuit sets the level
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// >>> verif/gpio_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"
module gpio_bank_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [47:0] pin_out,
   input wire logic [47:0] pin_oe,
   input wire logic irq
);
   // ----------------------------------------
   // Bus phases
   // ----------------------------------------
   // Frozen clock enable stalls the bus, so it disables checking
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst || !ce);
   sequence s_acc;
      psel && penable && !pready;
   endsequence
   sequence s_wr(logic [3:0] i);
      psel && penable && pready && pwrite && paddr[7:2] == {2'b00, i};
   endsequence
   property p_ans;
      s_acc |=> pready;
   endproperty
   property p_err;
      s_acc ##0 (paddr[7:6] == 2'b11) |=> pready && pslverr && prdata == 32'h0;
   endproperty
   property p_ok;
      s_acc ##0 (paddr[7:6] != 2'b11 && paddr[5:2] <= 4'hc) |=> !pslverr && prdata[31:16] == 16'h0;
   endproperty
   property p_hold;
      !(psel && penable && pready && pwrite) |=> $stable(pin_out) && $stable(pin_oe);
   endproperty
   property p_set;
      s_wr(`GPIO_REG_SET) |=> pin_out[15:0] == ($past(pin_out[15:0]) | $past(pwdata[15:0]));
   endproperty
   property p_clr;
      s_wr(`GPIO_REG_CLEAR) |=> pin_out[15:0] == ($past(pin_out[15:0]) & ~$past(pwdata[15:0]));
   endproperty
   property p_tgl;
      s_wr(`GPIO_REG_TOGGLE) |=> pin_out[15:0] == ($past(pin_out[15:0]) ^ $past(pwdata[15:0]));
   endproperty
   property p_data;
      s_wr(`GPIO_REG_DATA) |=> pin_out[15:0] == $past(pwdata[15:0]);
   endproperty
   property p_dir;
      s_wr(`GPIO_REG_DIR) |=> pin_oe[15:0] == $past(pwdata[15:0]);
   endproperty
   property p_rst;
      $fell(sys_rst) |-> pin_out == 48'h0 && pin_oe == 48'h0 && !irq;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer one cycle into access");
   a_err: assert property (p_err) else $error("bank four not refused");
   a_ok: assert property (p_ok) else $error("mapped access refused");
   a_hold: assert property (p_hold) else $error("pins moved without write");
   a_set: assert property (p_set) else $error("set write wrong");
   a_clr: assert property (p_clr) else $error("clear write wrong");
   a_tgl: assert property (p_tgl) else $error("toggle write wrong");
   a_data: assert property (p_data) else $error("data write wrong");
   a_dir: assert property (p_dir) else $error("direction write wrong");
   a_rst: assert property (p_rst) else $error("pins active after reset");
endmodule
bind gpio_port_bank_controller gpio_bank_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
   .irq(irq));
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_bank_regs.svh"
module tb;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, e, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [47:0] pin_in, pin_out, pin_oe, ext, eo, ed;
   logic [15:0] v, w;
   int num_errors, comparisons, seed;
   gpio_far_end far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
   gpio_port_bank_controller DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // 25 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task print_verdict;
      $display("counts: errors %0d compares %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [47:0] x, input logic [47:0] y);
      comparisons++;
      if (y !== x) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", s, x, y);
      end
   endtask
   function logic [11:0] ad(input int p, input logic [3:0] i);
      return {4'h0, p[1:0], i, 2'b00};
   endfunction
   // Expected output word after one of the four output writes
   function logic [15:0] nxt(input logic [3:0] i, input logic [15:0] c, input logic [15:0] d);
      case (i)
         `GPIO_REG_DATA: return d;
         `GPIO_REG_CLEAR: return c & ~d;
         `GPIO_REG_SET: return c | d;
         default: return c ^ d;
      endcase
   endfunction
   // One APB transfer, idle cycle after; no cycle count assumed
   task apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      if (n >= 20) begin
         num_errors++;
         print_verdict();
      end
   endtask
   task wait_irq(input logic x);
      int n;
      n = 0;
      while (irq !== x && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq", x, irq);
      if (n >= 20) print_verdict();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h0fad;
      num_errors = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, ext} = '0;
      ce = 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      for (int p = 0; p < 3; p++)
         for (int i = 0; i < 13; i++) begin
            apb(1'b0, ad(p, 4'(i)), 16'h0);
            chk("reset reg", 48'h0, q);
         end
      chk("reset oe", 48'h0, pin_oe);
      $display("test reset done");
      apb(1'b1, ad(3, `GPIO_REG_DATA), 16'hffff);
      chk("bank four err", 1'b1, e);
      chk("bank four pins", 48'h0, pin_out);
      apb(1'b0, ad(0, 4'hd), 16'h0);
      chk("bad index err", 1'b1, e);
      $display("test refusal done");
      eo = '0;
      ed = '0;
      // Random direction and output writes, one port at a time; others must not move
      for (int p = 0; p < 3; p++) begin
         v = 16'h0;
         w = 16'($random(seed));
         ed[16*p +: 16] = w;
         apb(1'b1, ad(p, `GPIO_REG_DIR), w);
         chk("oe", ed, pin_oe);
         for (int k = 0; k < 12; k++) begin
            w = (k == 5) ? 16'hffff : 16'($random(seed));
            v = nxt(4'(k % 4), v, w);
            eo[16*p +: 16] = v;
            apb(1'b1, ad(p, 4'(k % 4)), w);
            chk("pin_out", eo, pin_out);
         end
         apb(1'b0, ad(p, `GPIO_REG_DATA), 16'h0);
         chk("data read", v, q);
         ed[16*p +: 16] = 16'h0;
         apb(1'b1, ad(p, `GPIO_REG_DIR), 16'h0);
         apb(1'b1, ad(p, `GPIO_REG_INEN), 16'hffff);
         ext <= 48'($random(seed)) << (16 * p);
         repeat (3) @(posedge sys_clk);
         apb(1'b0, ad(p, `GPIO_REG_LEVEL), 16'h0);
         chk("level", ext[16*p +: 16], q);
         apb(1'b0, ad(p, `GPIO_REG_IRQ_STAT), 16'h0);
         chk("level stat", ext[16*p +: 16], q);
         chk("masked irq", 1'b0, irq);
      end
      $display("test pins done");
      // Edge interrupt on port 1 pin 3
      ext <= 48'h0;
      apb(1'b1, ad(1, `GPIO_REG_EDGE), 16'h0008);
      apb(1'b1, ad(1, `GPIO_REG_IRQ_STAT), 16'h0008);
      apb(1'b1, ad(1, `GPIO_REG_MASK_SET), 16'h0008);
      ext[19] <= 1'b1;
      wait_irq(1'b1);
      ext[19] <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("edge latched", 1'b1, irq);
      apb(1'b1, ad(1, `GPIO_REG_IRQ_STAT), 16'h0008);
      wait_irq(1'b0);
      apb(1'b1, ad(1, `GPIO_REG_BOTH), 16'h0008);
      ext[19] <= 1'b1;
      wait_irq(1'b1);
      apb(1'b1, ad(1, `GPIO_REG_IRQ_STAT), 16'h0008);
      ext[19] <= 1'b0;
      wait_irq(1'b1);
      apb(1'b1, ad(1, `GPIO_REG_MASK_CLEAR), 16'h0008);
      wait_irq(1'b0);
      apb(1'b0, ad(1, `GPIO_REG_MASK), 16'h0);
      chk("mask", 48'h0, q);
      $display("test edge irq done");
      // Level mode follows the pin
      apb(1'b1, ad(1, `GPIO_REG_EDGE), 16'h0);
      apb(1'b1, ad(1, `GPIO_REG_MASK_SET), 16'h0008);
      ext[19] <= 1'b1;
      wait_irq(1'b1);
      ext[19] <= 1'b0;
      wait_irq(1'b0);
      // Output pin raised by software write
      apb(1'b1, ad(1, `GPIO_REG_EDGE), 16'h0008);
      apb(1'b1, ad(1, `GPIO_REG_BOTH), 16'h0);
      apb(1'b1, ad(1, `GPIO_REG_DATA), 16'h0);
      apb(1'b1, ad(1, `GPIO_REG_DIR), 16'h0008);
      apb(1'b1, ad(1, `GPIO_REG_IRQ_STAT), 16'h0008);
      chk("quiet", 1'b0, irq);
      apb(1'b1, ad(1, `GPIO_REG_SET), 16'h0008);
      wait_irq(1'b1);
      $display("test output irq done");
      // Low clock enable: a pin change must not enter the synchroniser
      ce <= 1'b0;
      ext[0] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ce <= 1'b1;
      apb(1'b0, ad(0, `GPIO_REG_LEVEL), 16'h0);
      chk("frozen level", 1'b0, q[0]);
      apb(1'b0, ad(0, `GPIO_REG_LEVEL), 16'h0);
      chk("thawed level", 1'b1, q[0]);
      $display("test clock enable done");
      print_verdict();
   end
endmodule
`default_nettype wire
